// ---- core/fdc_cmd_pkg.sv ----
package fdc_cmd_pkg;
    // Opcodes, low five bits of byte one
    localparam logic [4:0] OP_SCAN_EQ = 5'h11;
    localparam logic [4:0] OP_SCAN_LE = 5'h19;
    localparam logic [4:0] OP_SCAN_HE = 5'h1D;
    localparam logic [4:0] OP_SEEK = 5'h0F;
    localparam logic [4:0] OP_SENSE_DRV = 5'h04;
    localparam logic [4:0] OP_SENSE_INT = 5'h08;
    // Full first byte of a sense interrupt
    localparam logic [7:0] SENSE_INT_FULL = 8'h08;
    // Command lengths in bytes
    localparam int SCAN_LEN = 9;
    localparam int SEEK_LEN = 3;
    localparam int SEEK_LEN_ETR = 4;
    localparam int SDS_LEN = 2;
    // Status register 0 cause codes, bits 7..5
    localparam logic [2:0] CAUSE_READY = 3'h6;
    localparam logic [2:0] CAUSE_SEEK_OK = 3'h1;
    localparam logic [2:0] CAUSE_SEEK_BAD = 3'h3;
    // Invalid command answer
    localparam logic [7:0] INVALID_ST0 = 8'h80;
    // Scan termination codes in bits 3..2
    localparam logic [1:0] SCAN_EQUAL = 2'h2;
    localparam logic [1:0] SCAN_STRICT = 2'h0;
    localparam logic [1:0] SCAN_NOT_MET = 2'h1;
    // Field positions of the second command byte
    localparam int HEAD_BIT = 2;
    localparam int IMPLIED_BIT = 7;
    // One timing unit is 1 ms
    localparam int CLK_HZ = 25000000;
    localparam int UNIT_US = 1000;
    localparam int UNIT_CYCLES = CLK_HZ / 1000000 * UNIT_US;
    localparam logic [3:0] SRT_RESET = 4'h0;
    localparam logic [6:0] MNT_RESET = 7'h00;
    localparam int MNT_ZERO_AS = 128;
    localparam int STEP_BASE = 16;

    typedef enum logic [1:0] {SCAN_MODE_EQ, SCAN_MODE_LE, SCAN_MODE_HE} scan_mode_t;

    // Scan parameters for the data path
    typedef struct packed {
        logic multiTrack;
        logic modulationSelect;
        logic skipDeleted;
        logic impliedSeek;
        logic headSelect;
        logic [1:0] driveSelect;
        logic [7:0] track;
        logic [7:0] headNum;
        logic [7:0] sector;
        logic [7:0] sizeCode;
        logic [7:0] endSector;
        logic [7:0] gapLength;
        logic [7:0] sectorStep;
    } scan_params_t;

    // Drive step interface
    typedef struct packed {
        logic stepPulse;
        logic headDirIn;
        logic [1:0] drive;
    } step_out_t;

    // Status register 3 inputs
    typedef struct packed {
        logic fault;
        logic writeProt;
        logic ready;
        logic track0;
        logic twoSide;
    } drv_sense_t;
endpackage

// ---- core/fdc_byte_fifo.sv ----
module fdc_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r;
    logic [AW-1:0] rdPtr_r;
    logic [AW:0] count_r;
    logic doWr;
    logic doRd;

    // Handshakes
    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;
    assign outData = mem[rdPtr_r];

    // Storage
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doWr) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule

// ---- core/fdc_seek_sense.sv ----
// What this block does
// R1 - Seek compares target to present track, steps
// R2 - Accepted seek sets that drive's busy flag
// R3 - Wait motor-on delay before first step
// R4 - Steps come from polling, not command phase
// R5 - Step interval equals programmed step rate
// R6 - Interrupt one step period later, no result
// R7 - Host seeks one drive, only sense interrupt
// R8 - Extended range adds fourth seek byte
// R9 - Sense drive status returns one byte, no interrupt
// R10 - Sense interrupt returns status, track, nibble only with extended range
// R11 - Interrupt on result entry or non-DMA transfer
// R12 - Interrupt on seek end or ready change
// R13 - Result/transfer interrupts clear on data access
// R14 - Seek/ready interrupts held until first result read
// R15 - Cause encoded in status zero bits 7..5
// R16 - Codes 110 ready, 001 normal, 011 abnormal
// R17 - Sense interrupt with none pending is invalid
// R18 - Scan takes nine bytes, compares data
// R19 - Low five bits 11001 decode scan low-or-equal
// R20 - Scan bits 3..2: 10 equal, 00 strict, 01 miss
// R21 - Second byte: bit 2 head, bits 1..0 drive
// R22 - After stepping, present track becomes target
module fdc_seek_sense #(
    parameter int TRACK_W = 12,
    parameter int FIFO_DEPTH = 16,
    parameter int UNIT_CYCLES = fdc_cmd_pkg::UNIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [7:0] cmdByte,
    output logic resValid,
    input wire logic resReady,
    output logic [7:0] resByte,
    input wire logic extended_track_range,
    input wire logic [3:0] stepRateCode,
    input wire logic [6:0] motorOnCode,
    input wire logic specifyLoad,
    input wire logic resultEntry,
    input wire logic nonDmaXfer,
    input wire logic dataRegAccess,
    input wire logic [3:0] driveReady,
    input wire logic pollEnable,
    input wire logic abortSeek,
    input wire fdc_cmd_pkg::drv_sense_t driveSense,
    input wire logic scanDone,
    input wire logic scanEqual,
    input wire logic scanCondMet,
    output fdc_cmd_pkg::scan_params_t scanParams,
    output fdc_cmd_pkg::scan_mode_t scanMode,
    output logic scanStart,
    output logic [1:0] scanResultCode,
    output fdc_cmd_pkg::step_out_t stepOut,
    output logic [3:0] drive_seek_busy_flag,
    output logic [TRACK_W-1:0] presentTrack [4],
    output logic intReq,
    output logic commandBusy
);
    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_MOTOR, ST_RESULT} ph_t;

    // Head and drive fields of byte two
    function automatic logic [2:0] head_drive(input logic [7:0] b);
        return {b[fdc_cmd_pkg::HEAD_BIT], b[1:0]};
    endfunction

    ph_t phase_r;
    logic [7:0] cmdBuf_r [9];
    logic [3:0] cmdCnt_r;
    logic [3:0] cmdLen;
    logic [7:0] resBuf_r [3];
    logic [1:0] resCnt_r;
    logic [1:0] resLen_r;
    logic [3:0] srt_r;
    logic [6:0] mnt_r;
    logic [19:0] unitCnt_r;
    logic unitTick;
    logic slotDone;
    logic seekEnd;
    logic readyChg;
    logic [7:0] motorCnt_r;
    logic [4:0] stepCnt_r;
    logic seeking_r;
    logic [1:0] seekDrv_r;
    logic seekHead_r;
    logic [TRACK_W-1:0] target_r;
    logic [TRACK_W-1:0] ptr_r [4];
    logic stepPending_r;
    logic lastStepDone_r;
    logic autoInt_r;
    logic seekInt_r;
    logic [2:0] cause_r;
    logic [1:0] causeDrv_r;
    logic causeHead_r;
    logic [3:0] rdyPrev_r;
    logic fifoValid;
    logic fifoTake;
    logic [7:0] fifoByte;
    logic firstRead;
    logic [4:0] op;

    ////////////////////////////////////////////////////////////////
    // Command byte buffer
    fdc_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) cmdFifo (
        .clk(sys_clk),
        .rst(rst),
        .inValid(cmdValid),
        .inReady(cmdReady),
        .inData(cmdByte),
        .outValid(fifoValid),
        .outReady(fifoTake),
        .outData(fifoByte)
    );

    // Drain only while collecting
    assign fifoTake = fifoValid && (phase_r == ST_IDLE || phase_r == ST_CMD);
    assign op = (phase_r == ST_IDLE) ? fifoByte[4:0] : cmdBuf_r[0][4:0];

    // Command length from the first byte
    always_comb begin
        unique case (op)
            fdc_cmd_pkg::OP_SCAN_EQ, fdc_cmd_pkg::OP_SCAN_LE,
            fdc_cmd_pkg::OP_SCAN_HE: cmdLen = 4'(fdc_cmd_pkg::SCAN_LEN); // R18
            fdc_cmd_pkg::OP_SEEK: cmdLen = extended_track_range ?
                4'(fdc_cmd_pkg::SEEK_LEN_ETR) : 4'(fdc_cmd_pkg::SEEK_LEN); // R8
            fdc_cmd_pkg::OP_SENSE_DRV: cmdLen = 4'(fdc_cmd_pkg::SDS_LEN);
            default: cmdLen = 4'h1;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // 1 ms tick and specify values
    assign unitTick = (unitCnt_r == 20'(UNIT_CYCLES - 1));

    always_ff @(posedge sys_clk) begin
        if (rst || unitTick) begin
            unitCnt_r <= '0;
        end else begin
            unitCnt_r <= unitCnt_r + 20'h00001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            srt_r <= fdc_cmd_pkg::SRT_RESET;
            mnt_r <= fdc_cmd_pkg::MNT_RESET;
        end else if (specifyLoad) begin
            srt_r <= stepRateCode;
            mnt_r <= motorOnCode;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Command, motor-on and result phases
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_r <= ST_IDLE;
            cmdCnt_r <= '0;
            resCnt_r <= '0;
            resLen_r <= '0;
            motorCnt_r <= '0;
            scanStart <= 1'b0;
            scanMode <= fdc_cmd_pkg::SCAN_MODE_EQ;
            scanParams <= '0;
            cmdBuf_r <= '{default: '0};
            resBuf_r <= '{default: '0};
        end else begin
            scanStart <= 1'b0;
            unique case (phase_r)
                ST_IDLE, ST_CMD: begin
                    if (fifoTake) begin
                        cmdBuf_r[cmdCnt_r] <= fifoByte;
                        if (cmdCnt_r + 4'h1 == cmdLen) begin
                            cmdCnt_r <= '0;
                            phase_r <= ST_RESULT;
                            resCnt_r <= '0;
                            resLen_r <= 2'h0;
                            unique case (op)
                                fdc_cmd_pkg::OP_SEEK: begin
                                    phase_r <= ST_MOTOR; // R3
                                    motorCnt_r <= (mnt_r == '0) ? 8'(fdc_cmd_pkg::MNT_ZERO_AS) : {1'b0, mnt_r};
                                end
                                fdc_cmd_pkg::OP_SENSE_DRV: begin
                                    // One byte, no interrupt
                                    resBuf_r[0] <= {driveSense, head_drive(fifoByte)}; // R9 R21
                                    resLen_r <= 2'h1;
                                end
                                fdc_cmd_pkg::OP_SENSE_INT: begin
                                    if (fifoByte == fdc_cmd_pkg::SENSE_INT_FULL && seekInt_r) begin
                                        resBuf_r[0] <= {cause_r, 2'b00, causeHead_r, causeDrv_r}; // R15 R10
                                        resBuf_r[1] <= ptr_r[causeDrv_r][7:0];
                                        resBuf_r[2] <= {4'(ptr_r[causeDrv_r] >> 8), 4'h0};
                                        resLen_r <= extended_track_range ? 2'h3 : 2'h2;
                                    end else begin
                                        resBuf_r[0] <= fdc_cmd_pkg::INVALID_ST0; // R17
                                        resLen_r <= 2'h1;
                                    end
                                end
                                fdc_cmd_pkg::OP_SCAN_EQ, fdc_cmd_pkg::OP_SCAN_LE, fdc_cmd_pkg::OP_SCAN_HE: begin
                                    phase_r <= ST_IDLE;
                                    scanStart <= 1'b1; // R18
                                    scanMode <= (op == fdc_cmd_pkg::OP_SCAN_LE) ? fdc_cmd_pkg::SCAN_MODE_LE : // R19
                                        (op == fdc_cmd_pkg::OP_SCAN_HE) ? fdc_cmd_pkg::SCAN_MODE_HE :
                                        fdc_cmd_pkg::SCAN_MODE_EQ;
                                    scanParams <= {cmdBuf_r[0][7:5], cmdBuf_r[1][fdc_cmd_pkg::IMPLIED_BIT],
                                        head_drive(cmdBuf_r[1]), cmdBuf_r[2], cmdBuf_r[3], cmdBuf_r[4],
                                        cmdBuf_r[5], cmdBuf_r[6], cmdBuf_r[7], fifoByte}; // R21
                                end
                                default: begin
                                    resBuf_r[0] <= fdc_cmd_pkg::INVALID_ST0;
                                    resLen_r <= 2'h1;
                                end
                            endcase
                        end else begin
                            cmdCnt_r <= cmdCnt_r + 4'h1;
                            phase_r <= ST_CMD;
                        end
                    end
                end
                ST_MOTOR: begin
                    if (unitTick) begin
                        motorCnt_r <= motorCnt_r - 8'h01;
                        if (motorCnt_r == 8'h01) begin
                            phase_r <= ST_IDLE; // R4 R6
                        end
                    end
                end
                ST_RESULT: begin
                    if (resLen_r == '0) begin
                        phase_r <= ST_IDLE;
                    end else if (resValid && resReady) begin
                        resCnt_r <= resCnt_r + 2'h1;
                        if (resCnt_r + 2'h1 == resLen_r) begin
                            phase_r <= ST_IDLE;
                        end
                    end
                end
                default: phase_r <= ST_IDLE;
            endcase
        end
    end

    assign resValid = (phase_r == ST_RESULT) && (resCnt_r < resLen_r);
    assign resByte = resBuf_r[resCnt_r];
    assign firstRead = resValid && resReady && resCnt_r == '0;
    assign commandBusy = (phase_r != ST_IDLE);

    ////////////////////////////////////////////////////////////////
    // Seek start and polled stepping
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seeking_r <= 1'b0;
            seekDrv_r <= '0;
            seekHead_r <= 1'b0;
            target_r <= '0;
            stepPending_r <= 1'b0;
            lastStepDone_r <= 1'b0;
            stepCnt_r <= '0;
            stepOut <= '0;
            drive_seek_busy_flag <= '0;
            for (int i = 0; i < 4; i++) begin
                ptr_r[i] <= '0;
            end
        end else begin
            stepOut.stepPulse <= 1'b0;
            if (phase_r == ST_CMD && fifoTake && cmdCnt_r + 4'h1 == cmdLen && op == fdc_cmd_pkg::OP_SEEK) begin
                seeking_r <= 1'b1;
                seekDrv_r <= cmdBuf_r[1][1:0];
                seekHead_r <= cmdBuf_r[1][fdc_cmd_pkg::HEAD_BIT];
                stepOut.drive <= cmdBuf_r[1][1:0];
                drive_seek_busy_flag[cmdBuf_r[1][1:0]] <= 1'b1; // R2
                target_r <= extended_track_range ? TRACK_W'({fifoByte[7:4], cmdBuf_r[2]}) : TRACK_W'(fifoByte); // R8
                stepPending_r <= 1'b0;
                lastStepDone_r <= 1'b0;
                stepCnt_r <= '0;
            end else if (seeking_r && phase_r != ST_MOTOR && pollEnable && unitTick) begin
                // One step per step-rate slot
                if (slotDone) begin // R5
                    stepCnt_r <= '0;
                    if (seekEnd) begin
                        // Slot after the last step ends the seek
                        seeking_r <= 1'b0; // R6
                        drive_seek_busy_flag[seekDrv_r] <= 1'b0;
                    end else begin
                        stepOut.stepPulse <= 1'b1; // R4
                        stepOut.headDirIn <= (target_r > ptr_r[seekDrv_r]); // R1
                        ptr_r[seekDrv_r] <= (target_r > ptr_r[seekDrv_r]) ?
                            ptr_r[seekDrv_r] + 1'b1 : ptr_r[seekDrv_r] - 1'b1; // R1 R22
                    end
                end else begin
                    stepCnt_r <= stepCnt_r + 5'h01;
                end
            end
        end
    end

    assign presentTrack = ptr_r;

    ////////////////////////////////////////////////////////////////
    // Interrupt sources and clearing
    assign slotDone = stepCnt_r + 5'h01 >= 5'(fdc_cmd_pkg::STEP_BASE) - {1'b0, srt_r};
    assign seekEnd = seeking_r && phase_r != ST_MOTOR && pollEnable && unitTick && slotDone
        && (abortSeek || ptr_r[seekDrv_r] == target_r);
    assign readyChg = pollEnable && (driveReady != rdyPrev_r);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdyPrev_r <= '0;
        end else if (pollEnable) begin
            rdyPrev_r <= driveReady;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            autoInt_r <= 1'b0;
        end else if (resultEntry || nonDmaXfer) begin
            autoInt_r <= 1'b1; // R11
        end else if (dataRegAccess || firstRead) begin
            autoInt_r <= 1'b0; // R13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seekInt_r <= 1'b0;
            cause_r <= '0;
            causeDrv_r <= '0;
            causeHead_r <= 1'b0;
        end else if (seekEnd) begin
            seekInt_r <= 1'b1; // R12
            cause_r <= abortSeek ? fdc_cmd_pkg::CAUSE_SEEK_BAD : fdc_cmd_pkg::CAUSE_SEEK_OK; // R16
            causeDrv_r <= seekDrv_r;
            causeHead_r <= seekHead_r;
        end else if (readyChg) begin
            seekInt_r <= 1'b1; // R12
            cause_r <= fdc_cmd_pkg::CAUSE_READY; // R16
        end else if (firstRead && resLen_r >= 2'h2) begin
            seekInt_r <= 1'b0; // R14
        end
    end

    assign intReq = autoInt_r || seekInt_r;

    // Scan termination code for status register 2
    assign scanResultCode = !scanDone ? 2'h0 : scanEqual ? fdc_cmd_pkg::SCAN_EQUAL : // R20
        scanCondMet ? fdc_cmd_pkg::SCAN_STRICT : fdc_cmd_pkg::SCAN_NOT_MET;
endmodule

// ---- testbench/fdc_seek_sense_props.sv ----
module fdc_seek_sense_props #(
    parameter int UNIT_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic resValid,
    input wire logic resReady,
    input wire logic [7:0] resByte,
    input wire logic pollEnable,
    input wire logic [3:0] driveReady,
    input wire logic dataRegAccess,
    input wire logic resultEntry,
    input wire logic scanDone,
    input wire logic scanEqual,
    input wire logic scanCondMet,
    input wire logic [1:0] scanResultCode,
    input wire logic [3:0] stepRateCode,
    input wire logic specifyLoad,
    input wire fdc_cmd_pkg::step_out_t stepOut,
    input wire logic [3:0] drive_seek_busy_flag,
    input wire logic intReq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] rate_r;
    int gap_r;
    int stepN;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // Step rate copy, cycles since last step
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rate_r <= 4'h0;
            gap_r <= 0;
        end else begin
            if (specifyLoad) begin
                rate_r <= stepRateCode;
            end
            gap_r <= stepOut.stepPulse ? 1 : gap_r + 1;
        end
    end
    assign stepN = (16 - int'(rate_r)) * UNIT_CYCLES;
    // Checks
    chk_step_gap: assert property (stepOut.stepPulse && gap_r <= stepN |-> gap_r == stepN)
        else $error("step interval wrong");
    chk_step_busy: assert property (stepOut.stepPulse |-> drive_seek_busy_flag[stepOut.drive])
        else $error("step without busy");
    chk_step_poll: assert property (stepOut.stepPulse |-> $past(pollEnable))
        else $error("step outside polling");
    chk_end_int: assert property ($fell(|drive_seek_busy_flag) |-> intReq)
        else $error("no interrupt at seek end");
    chk_int_held: assert property (intReq && !(resValid && resReady) && !dataRegAccess |=> intReq)
        else $error("interrupt dropped");
    chk_auto_int: assert property (resultEntry |=> intReq)
        else $error("no result interrupt");
    chk_ready_int: assert property (pollEnable && driveReady != $past(driveReady) |-> ##[0:3] intReq)
        else $error("no ready interrupt");
    chk_scan_eq: assert property (scanDone && scanEqual |-> scanResultCode == 2'h2)
        else $error("scan equal code wrong");
    chk_scan_met: assert property (scanDone && !scanEqual |-> scanResultCode == (scanCondMet ? 2'h0 : 2'h1))
        else $error("scan code wrong");
    chk_res_hold: assert property (resValid && !resReady |=> resValid && $stable(resByte))
        else $error("result byte not held");
    cover property (stepOut.stepPulse);
    cover property ($fell(|drive_seek_busy_flag));
    cover property (scanDone && scanEqual);
endmodule

bind fdc_seek_sense fdc_seek_sense_props #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (.*);

// ---- testbench/fdc_drive_model.sv ----
module fdc_drive_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire fdc_cmd_pkg::step_out_t stepOut,
    input wire logic faultIn,
    input wire logic protIn,
    output fdc_cmd_pkg::drv_sense_t driveSense,
    output int headPos [4]
);
    timeunit 1ns;
    timeprecision 100ps;
    ////////////////////////////////////////
    // Step moves head one track, high is inward
    always @(posedge sys_clk) begin
        if (rst) begin
            headPos <= '{4{0}};
        end else if (stepOut.stepPulse === 1'b1) begin
            headPos[stepOut.drive] <= headPos[stepOut.drive] + (stepOut.headDirIn ? 1 : -1);
        end
    end
    // Status lines of the drive on the step interface (stepOut.drive, set by the last seek)
    assign driveSense = '{faultIn, protIn, 1'b1, headPos[stepOut.drive] == 0, 1'b1};
endmodule

// ---- testbench/fdc_seek_sense_test.sv ----
module fdc_seek_sense_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic resReady = 1'b0;
    logic cmdValid, cmdReady, resValid, extended_track_range, specifyLoad, resultEntry, nonDmaXfer;
    logic dataRegAccess, pollEnable, abortSeek, scanDone, scanEqual, scanCondMet, scanStart, intReq;
    logic commandBusy, hold, scanSeen, faultIn, protIn;
    logic [7:0] cmdByte, resByte;
    logic [7:0] sb [9];
    logic [7:0] expQ [$];
    logic [7:0] mskQ [$];
    logic [3:0] stepRateCode, driveReady, drive_seek_busy_flag;
    logic [6:0] motorOnCode;
    logic [1:0] scanResultCode;
    logic [11:0] presentTrack [4];
    logic [4:0] ops [3] = '{5'h11, 5'h19, 5'h1D};
    logic [1:0] modes [3] = '{fdc_cmd_pkg::SCAN_MODE_EQ, fdc_cmd_pkg::SCAN_MODE_LE, fdc_cmd_pkg::SCAN_MODE_HE};
    int headPos [4];
    int errors = 0;
    int n_tests = 0;
    int seed = 48;
    fdc_cmd_pkg::drv_sense_t driveSense;
    fdc_cmd_pkg::scan_params_t scanParams, sp;
    fdc_cmd_pkg::scan_mode_t scanMode, sm;
    fdc_cmd_pkg::step_out_t stepOut;

    fdc_seek_sense #(.UNIT_CYCLES(4)) u_dut (.*);
    fdc_drive_model u_drv (.*);
    ////////////////////////////////////////
    always #20 sys_clk = ~sys_clk;
    // Host reads results at random
    always @(posedge sys_clk) begin
        if (scanStart === 1'b1) begin
            scanSeen <= 1'b1;
            sp <= scanParams;
            sm <= scanMode;
        end
        if (resValid === 1'b1 && resReady === 1'b1) begin
            if (expQ.size() == 0) chk("extra result", resByte, 16'hFFFF);
            else chk("result", resByte & mskQ.pop_front(), expQ.pop_front());
        end
        #1 resReady = hold ? 1'b0 : 1'($random(seed));
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic note(input logic [7:0] v, input logic [7:0] m);
        expQ.push_back(v & m);
        mskQ.push_back(m);
    endtask
    task automatic send(input logic [7:0] b);
        cmdByte = b;
        cmdValid = 1'b1;
        while (cmdReady !== 1'b1) cyc(1);
        cyc(1);
    endtask
    task automatic drain();
        cmdValid = 1'b0;
        for (int i = 0; i < 400 && expQ.size() > 0; i++) cyc(1);
        cyc(1);
        chk("results left", 16'(expQ.size()), 16'h0000);
        chk("idle", commandBusy, 1'b0);
    endtask
    // One drive at a time, sense interrupt only
    task automatic seek(input logic [1:0] d, input logic h, input logic [11:0] t, input logic e);
        extended_track_range = e;
        send(8'h0F);
        send({5'h00, h, d});
        send(t[7:0]);
        if (e) send({t[11:8], 4'h0});
        cmdValid = 1'b0;
        cyc(3);
        chk("busy", drive_seek_busy_flag[d], 1'b1);
        for (int i = 0; i < 3000 && drive_seek_busy_flag[d]; i++) cyc(1);
        chk("seek int", intReq, 1'b1);
        chk("no result", resValid, 1'b0);
        if (!abortSeek) chk("head", 16'(headPos[d]), 16'(t));
        if (!abortSeek) chk("track", presentTrack[d], t);
    endtask
    task automatic sense_int(input logic [2:0] c, input logic [11:0] p, input logic [7:0] m);
        note({c, 5'h00}, 8'hE0);
        note(p[7:0], m);
        if (extended_track_range) note({p[11:8], 4'h0}, m);
        send(8'h08);
        drain();
        chk("int cleared", intReq, 1'b0);
    endtask
    task automatic wrap_up();
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        {cmdValid, specifyLoad, resultEntry, nonDmaXfer, dataRegAccess, abortSeek, extended_track_range} = '0;
        {scanDone, scanEqual, scanCondMet, hold, scanSeen, faultIn, protIn, driveReady} = '0;
        {cmdByte, pollEnable, stepRateCode, motorOnCode} = {8'h00, 1'b1, 4'hE, 7'h01};
        repeat (5) @(posedge sys_clk);
        #1 rst = 1'b0;
        specifyLoad = 1'b1;
        cyc(1);
        specifyLoad = 1'b0;
        note(fdc_cmd_pkg::INVALID_ST0, 8'hFF);
        send(8'h08);
        drain();
        {faultIn, protIn} = 2'($random(seed));
        note({faultIn, protIn, 3'h7, 1'b1, 2'h2}, 8'hFF);
        send(8'h04);
        send(8'h06);
        drain();
        chk("drive status int", intReq, 1'b0);
        seek(2'h1, 1'b0, 12'h003, 1'b0);
        sense_int(3'h1, 12'h003, 8'hFF);
        seek(2'h1, 1'b1, 12'h102, 1'b1);
        sense_int(3'h1, 12'h102, 8'hFF);
        seek(2'h1, 1'b0, 12'h001, 1'b0);
        sense_int(3'h1, 12'h001, 8'hFF);
        abortSeek = 1'b1;
        seek(2'h2, 1'b0, 12'h009, 1'b0);
        abortSeek = 1'b0;
        sense_int(3'h3, 12'h000, 8'h00);
        driveReady = 4'h4;
        cyc(4);
        chk("ready int", intReq, 1'b1);
        sense_int(3'h6, 12'h000, 8'h00);
        for (int i = 0; i < 2; i++) begin
            {resultEntry, nonDmaXfer} = (i == 0) ? 2'h2 : 2'h1;
            cyc(1);
            {resultEntry, nonDmaXfer, dataRegAccess} = 3'h1;
            chk("auto int", intReq, 1'b1);
            cyc(1);
            dataRegAccess = 1'b0;
            cyc(1);
            chk("auto clear", intReq, 1'b0);
        end
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 9; j++) sb[j] = 8'($random(seed));
            sb[0][4:0] = ops[k];
            scanSeen = 1'b0;
            for (int j = 0; j < 9; j++) send(sb[j]);
            cmdValid = 1'b0;
            cyc(4);
            chk("scan start", scanSeen, 1'b1);
            chk("scan mode", sm, modes[k]);
            chk("scan flags", {sp.multiTrack, sp.modulationSelect, sp.skipDeleted, sp.impliedSeek},
                {sb[0][7:5], sb[1][7]});
            chk("scan drive", {sp.headSelect, sp.driveSelect}, sb[1][2:0]);
            chk("scan step", sp.sectorStep, sb[8]);
            for (int c = 0; c < 8; c++) begin
                {scanDone, scanEqual, scanCondMet} = 3'(c);
                cyc(1);
                chk("scan code", scanResultCode, !c[2] ? 2'h0 : c[1] ? 2'h2 : c[0] ? 2'h0 : 2'h1);
            end
            {scanDone, scanEqual, scanCondMet} = 3'h0;
        end
        hold = 1'b1;
        cyc(1);
        cmdByte = 8'h08;
        cmdValid = 1'b1;
        for (int i = 0; i < 20; i++) begin
            if (cmdReady === 1'b1) note(fdc_cmd_pkg::INVALID_ST0, 8'hFF);
            cyc(1);
        end
        cmdValid = 1'b0;
        chk("buffer full", cmdReady, 1'b0);
        chk("held", commandBusy, 1'b1);
        hold = 1'b0;
        drain();
        wrap_up();
    end
endmodule
